// *** dv/smbus_host_model.sv ***
// Purpose: behavioural two-wire bus host driving the serial clock and data line
// Assumes: the bench resolves the open-drain data line with a pull-up
// Notes:   clock stands high outside frames; bit period 320 ns
`timescale 1ns/1ns
`default_nettype none
module smbus_host_model (
  output logic      scl,
  output logic      pullLow,
  input  wire logic sda
);
  initial begin
    scl = 1'b1;
    pullLow = 1'b0;
  end

  // data moves only while the clock is low, sampled late in the high phase
  task automatic xfer_bit(input logic b, output logic r);
    pullLow = ~b;
    #80;
    scl = 1'b1;
    #160;
    r = sda;
    scl = 1'b0;
    #80;
  endtask

  task automatic start_cond;
    pullLow = 1'b0;
    #80;
    scl = 1'b1;
    #160;
    pullLow = 1'b1;
    #160;
    scl = 1'b0;
    #80;
  endtask

  task automatic stop_cond;
    pullLow = 1'b1;
    #80;
    scl = 1'b1;
    #160;
    pullLow = 1'b0;
    #160;
  endtask

  task automatic send_byte(input logic [7:0] d, output logic nack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xfer_bit(d[i], r);
    end
    xfer_bit(1'b1, nack);
  endtask

  // read byte with a final nack, as a single-byte read ends
  task automatic read_reg(input logic [6:0] addr, input logic [7:0] cmd,
                          output logic [7:0] d, output logic nack);
    logic n;
    start_cond;
    send_byte({addr, 1'b0}, nack);
    send_byte(cmd, n);
    start_cond;
    send_byte({addr, 1'b1}, n);
    for (int i = 7; i >= 0; i--) begin
      xfer_bit(1'b1, n);
      d[i] = n;
    end
    xfer_bit(1'b1, n);
    stop_cond;
  endtask
endmodule
`default_nettype wire

// *** dv/tb.sv ***
// Purpose: self-checking bench for the two-zone thermal event logic
// Assumes: strap pin high; bench models both converter inputs
// Notes:   each measurement takes 2001 cycles, so scenarios stay few
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic       sys_clk, nrst, regWr, regRd, irq, sclIn, sdaIn, hostLow, addrLsbStrap;
  logic       sdaOut, sdaOe, adcZoneRemote, adcStart;
  logic       eventOutN, eventOutNOe, overtempOutN, overtempOutNOe;
  logic [7:0] regAddr, regWdata, regRdata, adcData, localT, remoteT;
  int         fails;
  int         checks;
  logic [7:0] ra [7] = '{8'h03, 8'h02, 8'h13, 8'h12, 8'h23, 8'h22, 8'h05};
  logic [7:0] rv [7] = '{8'h51, 8'h4c, 8'h61, 8'h5c, 8'h61, 8'h5c, 8'h00};

  thermal_event_logic thermal_event_logic_inst (.*);
  smbus_host_model smbus_host_model_inst (.scl(sclIn), .pullLow(hostLow), .sda(sdaIn));

  // wired-and of both open-drain parties with a pull-up
  assign sdaIn = (sdaOe ? sdaOut : 1'b1) & ~hostLow;

  always #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    adcData <= adcZoneRemote ? remoteT : localT;
  end

  task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
    @(negedge sys_clk);
    d = regRdata;
  endtask

  // waits for the end of the next measurement of one zone plus the update lag
  task automatic wait_meas(input logic remote);
    int n;
    n = 0;
    while (!(adcStart === 1'b1 && adcZoneRemote === remote) && n < 9000) begin
      @(negedge sys_clk);
      n++;
    end
    @(negedge sys_clk);
    while (adcStart !== 1'b1 && n < 9000) begin
      @(negedge sys_clk);
      n++;
    end
    repeat (3) @(negedge sys_clk);
    check("measurement wait", {7'h00, n >= 9000}, 8'h00);
  endtask

  task automatic s_regs;
    logic [7:0] d;
    for (int i = 0; i < 7; i++) begin
      rd(ra[i], d);
      check("reset value", d, rv[i]);
    end
    wr(8'h00, 8'h55);
    rd(8'h00, d);
    check("temp read-only", d, 8'h00);
    wr(8'h01, 8'hfe);
    rd(8'h01, d);
    check("config bits", d, 8'h42);
    wr(8'h01, 8'h00);
  endtask

  task automatic s_serial;
    logic [7:0] d;
    logic       nack;
    smbus_host_model_inst.read_reg({thermal_pkg::ADDR_BASE_HI, 1'b1}, 8'h13, d, nack);
    check("own address ack", {7'h00, nack}, 8'h00);
    check("serial data", d, 8'h61);
    smbus_host_model_inst.read_reg({thermal_pkg::ADDR_BASE_HI, 1'b0}, 8'h13, d, nack);
    check("foreign address ack", {7'h00, nack}, 8'h01);
  endtask

  task automatic s_compare;
    logic [7:0] d;
    localT = 8'h60;
    wait_meas(1'b0);
    check("event pin above", {7'h00, eventOutNOe}, 8'h01);
    rd(8'h30, d);
    check("status above", d, 8'h01);
    wr(8'h31, 8'h01);
    @(negedge sys_clk);
    check("irq unmasked", {7'h00, irq}, 8'h01);
    wr(8'h30, 8'h01);
    @(negedge sys_clk);
    check("irq cleared", {7'h00, irq}, 8'h00);
    // negative reading is below hysteresis only when compared signed
    localT = 8'hf0;
    wait_meas(1'b0);
    check("event pin below", {7'h00, eventOutNOe}, 8'h00);
    check("irq on fall", {7'h00, irq}, 8'h01);
    wr(8'h31, 8'h00);
  endtask

  task automatic s_intr;
    logic [7:0] d;
    wr(8'h01, 8'h02);
    rd(8'h00, d);
    repeat (2) @(negedge sys_clk);
    check("int pin idle", {7'h00, eventOutNOe}, 8'h00);
    remoteT = 8'h70;
    wait_meas(1'b1);
    check("int pin latched", {7'h00, eventOutNOe}, 8'h01);
    check("overtemp pin", {7'h00, overtempOutNOe}, 8'h01);
    rd(8'h00, d);
    repeat (2) @(negedge sys_clk);
    check("int pin after read", {7'h00, eventOutNOe}, 8'h00);
    wr(8'h01, 8'h42);
    wr(8'h30, 8'h07);
    remoteT = 8'h10;
    wait_meas(1'b1);
    check("masked pin", {7'h00, eventOutNOe}, 8'h00);
    check("overtemp released", {7'h00, overtempOutNOe}, 8'h00);
    rd(8'h30, d);
    check("remote fall status", d & 8'h02, 8'h02);
  endtask

  task automatic final_report;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    sys_clk = 1'b0;
    nrst = 1'b0;
    regAddr = 8'h00;
    regWdata = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
    addrLsbStrap = 1'b1;
    localT = 8'h19;
    remoteT = 8'h19;
    fails = 0;
    checks = 0;
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    s_regs;
    s_serial;
    s_compare;
    s_intr;
    final_report;
  end

  // the scenarios need about 18000 cycles; this leaves ample room
  initial begin
    #2000000;
    fails++;
    final_report;
  end
endmodule
`default_nettype wire

// *** dv/thermal_event_chk.sv ***
// Purpose: port-level assertions on the two-zone thermal event logic
// Assumes: configuration is written only over the register port
// Notes:   shutdown is never used, so conversions alternate without a break
`timescale 1ns/1ns
`default_nettype none
module thermal_event_chk (
  input wire logic       sys_clk,
  input wire logic       nrst,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic       regWr,
  input wire logic       regRd,
  input wire logic       sdaOut,
  input wire logic       sdaOe,
  input wire logic       adcZoneRemote,
  input wire logic       adcStart,
  input wire logic       eventOutN,
  input wire logic       eventOutNOe,
  input wire logic       overtempOutN,
  input wire logic       overtempOutNOe
);
  localparam int RELEASE = 25;
  logic        maskR;
  logic        modeR;
  logic        lastRemote;
  logic        seen;
  logic [11:0] cnt;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      maskR <= 1'b0;
      modeR <= 1'b0;
    end else if (regWr && regAddr == thermal_pkg::REG_CONFIG) begin
      maskR <= regWdata[thermal_pkg::CFG_EVENT_MASK];
      modeR <= regWdata[thermal_pkg::CFG_MODE];
    end
  end

  // cycles since the last conversion start, saturating
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cnt <= 12'h000;
      seen <= 1'b0;
      lastRemote <= 1'b0;
    end else if (adcStart) begin
      cnt <= 12'h001;
      seen <= 1'b1;
      lastRemote <= adcZoneRemote;
    end else if (cnt != 12'hfff) begin
      cnt <= cnt + 12'h001;
    end
  end

  property p_sda_od;
    sdaOe |-> !sdaOut;
  endproperty
  a_sda_od: assert property (p_sda_od) else $error("data pin driven high");
  property p_evt_od;
    eventOutNOe |-> !eventOutN;
  endproperty
  a_evt_od: assert property (p_evt_od) else $error("event pin driven high");
  property p_overtemp_out_n_od;
    overtempOutNOe |-> !overtempOutN;
  endproperty
  a_overtemp_out_n_od: assert property (p_overtemp_out_n_od) else $error("overtemp pin driven high");
  property p_mask;
    maskR && $past(maskR, 2) |-> !eventOutNOe;
  endproperty
  a_mask: assert property (p_mask) else $error("masked event pin pulled low");
  property p_zone_alt;
    adcStart |-> adcZoneRemote != lastRemote;
  endproperty
  a_zone_alt: assert property (p_zone_alt) else $error("zone order broken");
  property p_conv_period;
    adcStart && seen |-> cnt == (lastRemote ? thermal_pkg::CONV_REMOTE_CYC
                                            : thermal_pkg::CONV_LOCAL_CYC) + 12'h001;
  endproperty
  a_conv_period: assert property (p_conv_period) else $error("conversion spacing wrong");
  property p_read_rel;
    modeR && regRd |-> ##[1:RELEASE] !eventOutNOe;
  endproperty
  a_read_rel: assert property (p_read_rel) else $error("read did not release event");
  property p_zone_mux;
    $changed(adcZoneRemote) |-> adcStart;
  endproperty
  a_zone_mux: assert property (p_zone_mux) else $error("mux moved mid conversion");
endmodule
bind thermal_event_logic thermal_event_chk thermal_event_chk_inst (.*);
`default_nettype wire

// *** inc/thermal_pkg.sv ***
// Purpose: shared constants and types of the two-zone thermal event logic
// Assumes: 25 MHz system clock; eight-bit register addresses and data
// Notes:   register offsets double as serial command bytes
package thermal_pkg;

  // register offsets (also the serial command byte values)
  localparam logic [7:0] REG_TEMP_LOCAL  = 8'h00;
  localparam logic [7:0] REG_CONFIG      = 8'h01;
  localparam logic [7:0] REG_HYST_LOCAL  = 8'h02;
  localparam logic [7:0] REG_SET_LOCAL   = 8'h03;
  localparam logic [7:0] REG_TEMP_REMOTE = 8'h10;
  localparam logic [7:0] REG_HYST_REMOTE = 8'h12;
  localparam logic [7:0] REG_SET_REMOTE  = 8'h13;
  localparam logic [7:0] REG_OVERTEMP_OUT_N_HYST   = 8'h22;
  localparam logic [7:0] REG_OVERTEMP_OUT_N_SET    = 8'h23;
  localparam logic [7:0] REG_STATUS      = 8'h30;
  localparam logic [7:0] REG_IRQ_MASK    = 8'h31;

  // values after reset, two's complement degrees
  localparam logic [7:0] RST_TEMP        = 8'h00;
  localparam logic [7:0] RST_CONFIG      = 8'h00;
  localparam logic [7:0] RST_SET_LOCAL   = 8'h51;
  localparam logic [7:0] RST_HYST_LOCAL  = 8'h4c;
  localparam logic [7:0] RST_SET_REMOTE  = 8'h61;
  localparam logic [7:0] RST_HYST_REMOTE = 8'h5c;
  localparam logic [7:0] RST_OVERTEMP_OUT_N_SET    = 8'h61;
  localparam logic [7:0] RST_OVERTEMP_OUT_N_HYST   = 8'h5c;
  localparam logic [2:0] RST_STATUS      = 3'h0;
  localparam logic [2:0] RST_IRQ_MASK    = 3'h0;

  // configuration fields
  localparam int         CFG_SHUTDOWN    = 0;
  localparam int         CFG_MODE        = 1;
  localparam int         CFG_EVENT_MASK  = 6;
  localparam logic [7:0] CFG_WR_MASK     = 8'h43;

  // status / irq mask fields
  localparam int         ST_LOCAL        = 0;
  localparam int         ST_REMOTE       = 1;
  localparam int         ST_OVERTEMP_OUT_N         = 2;

  // upper six client address bits of this variant
  localparam logic [5:0] ADDR_BASE_HI    = 6'h24;

  // conversion timing
  localparam int         CLK_PERIOD_NS   = 40;
  localparam int         CONV_LOCAL_NS   = 80000;
  localparam int         CONV_REMOTE_NS  = 80000;
  localparam logic [11:0] CONV_LOCAL_CYC  =
    12'((CONV_LOCAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] CONV_REMOTE_CYC =
    12'((CONV_REMOTE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int         CONV_CYCLE_NS   = CONV_LOCAL_NS + CONV_REMOTE_NS;
  localparam int         EVT_RELEASE_NS  = 1000;
  localparam int         EVT_RELEASE_CYC = EVT_RELEASE_NS / CLK_PERIOD_NS;

  // register write carrier
  typedef struct packed {
    logic       en;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_wr_t;

  typedef enum {
    SER_IDLE,
    SER_RX,
    SER_ACK,
    SER_TX,
    SER_MACK
  } ser_state_t;

endpackage

// *** src/thermal_event_logic.sv ***
// Purpose: two-zone temperature supervisor core with serial client port
// Assumes: converter result on adcData is valid when a conversion time ends
// Notes:   sclIn/sdaIn/addrLsbStrap are pins and are synchronised first
//
// Operation
// - address LSB taken from strap pin
// - upper six address bits fixed per variant
// - answer only own client address
// - data line pulled low only, else released
// - event output follows mode and mask bits
// - mask set keeps event output released
// - separate open-drain overtemperature output
// - eight-bit result, zone mux selects diode
// - results held as two's complement
// - event when result exceeds setpoint
// - later event when below hysteresis
// - conversions run continuously without commands
// - remote zone converted before local zone
// - outputs and status updated per measurement
// - cycle time is local plus remote; the sequencer adds one start cycle per zone
// - any register read releases event output in interrupt mode
`timescale 1ns/1ns
`default_nettype none
module thermal_event_logic (
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWdata,
  input  wire logic       regWr,
  input  wire logic       regRd,
  output logic      [7:0] regRdata,
  output logic            irq,
  input  wire logic       sclIn,
  input  wire logic       sdaIn,
  output logic            sdaOut,
  output logic            sdaOe,
  input  wire logic       addrLsbStrap,
  input  wire logic [7:0] adcData,
  output logic            adcZoneRemote,
  output logic            adcStart,
  output logic            eventOutN,
  output logic            eventOutNOe,
  output logic            overtempOutN,
  output logic            overtempOutNOe
);

  // register file
  logic [7:0] tempLocal_r;
  logic [7:0] tempRemote_r;
  logic [7:0] config_r;
  logic [7:0] setLocal_r;
  logic [7:0] hystLocal_r;
  logic [7:0] setRemote_r;
  logic [7:0] hystRemote_r;
  logic [7:0] critSet_r;
  logic [7:0] critHyst_r;
  logic [2:0] status_r;
  logic [2:0] irqMask_r;
  logic [7:0] regRdata_r;

  // sequencer and comparators
  logic        converting_r;
  logic        zoneRemote_r;
  logic [11:0] convCnt_r;
  logic        measDone;
  logic        aboveLocal_r;
  logic        aboveRemote_r;
  logic        critActive_r;
  logic        evtLocal;
  logic        evtRemote;
  logic        evtCrit;
  logic        intLatch_r;
  logic        eventOe_r;
  logic        anyRead;

  // serial port
  logic                       sclS1, sclS2, sclS3;
  logic                       sdaS1, sdaS2, sdaS3;
  logic                       strapS1, strapS2;
  logic                       addrLsb_r;
  logic [7:0]                 ptrData;
  logic                       sclRise, sclFall, busStart, busStop;
  thermal_pkg::ser_state_t    serState_r;
  logic [3:0]                 bitCnt_r;
  logic [7:0]                 shift_r;
  logic [1:0]                 byteNo_r;
  logic                       readMode_r;
  logic [7:0]                 ptr_r;
  logic                       sdaOe_r;
  logic                       serRd_r;
  thermal_pkg::reg_wr_t       serWr_r;
  thermal_pkg::reg_wr_t       wrSel;
  logic [6:0]                 ownAddr;

  function automatic logic sgt(input logic [7:0] a, input logic [7:0] b);
    sgt = $signed(a) > $signed(b);
  endfunction

  function automatic logic [7:0] regRead(input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    unique case (a)
      thermal_pkg::REG_TEMP_LOCAL:  v = tempLocal_r;
      thermal_pkg::REG_CONFIG:      v = config_r;
      thermal_pkg::REG_HYST_LOCAL:  v = hystLocal_r;
      thermal_pkg::REG_SET_LOCAL:   v = setLocal_r;
      thermal_pkg::REG_TEMP_REMOTE: v = tempRemote_r;
      thermal_pkg::REG_HYST_REMOTE: v = hystRemote_r;
      thermal_pkg::REG_SET_REMOTE:  v = setRemote_r;
      thermal_pkg::REG_OVERTEMP_OUT_N_HYST:   v = critHyst_r;
      thermal_pkg::REG_OVERTEMP_OUT_N_SET:    v = critSet_r;
      thermal_pkg::REG_STATUS:      v = {5'h00, status_r};
      thermal_pkg::REG_IRQ_MASK:    v = {5'h00, irqMask_r};
      default:                      v = 8'h00;
    endcase
    regRead = v;
  endfunction

  // ---------------- pin synchronisers ----------------
  // the host owns the bit clock; it is only sampled here
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sclS1   <= 1'b1;
      sclS2   <= 1'b1;
      sclS3   <= 1'b1;
      sdaS1   <= 1'b1;
      sdaS2   <= 1'b1;
      sdaS3   <= 1'b1;
      strapS1 <= 1'b0;
      strapS2 <= 1'b0;
    end else begin
      sclS1   <= sclIn;
      sclS2   <= sclS1;
      sclS3   <= sclS2;
      sdaS1   <= sdaIn;
      sdaS2   <= sdaS1;
      sdaS3   <= sdaS2;
      strapS1 <= addrLsbStrap;
      strapS2 <= strapS1;
    end
  end

  // the strap is tied, so following it needs no capture window after reset
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      addrLsb_r <= 1'b0;
    end else begin
      addrLsb_r <= strapS2;
    end
  end

  assign ownAddr  = {thermal_pkg::ADDR_BASE_HI, addrLsb_r};
  assign sclRise  = sclS2 && !sclS3;
  assign sclFall  = !sclS2 && sclS3;
  assign busStart = sclS2 && sclS3 && !sdaS2 && sdaS3;
  assign busStop  = sclS2 && sclS3 && sdaS2 && !sdaS3;

  // register contents at the serial pointer, for the read path
  always_comb begin
    ptrData = regRead(ptr_r);
  end

  // ---------------- serial client ----------------
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      serState_r <= thermal_pkg::SER_IDLE;
      bitCnt_r   <= 4'h0;
      shift_r    <= 8'h00;
      byteNo_r   <= 2'h0;
      readMode_r <= 1'b0;
      ptr_r      <= 8'h00;
      sdaOe_r    <= 1'b0;
      serRd_r    <= 1'b0;
      serWr_r    <= '0;
    end else begin
      serRd_r    <= 1'b0;
      serWr_r.en <= 1'b0;
      if (busStart) begin
        serState_r <= thermal_pkg::SER_RX;
        bitCnt_r   <= 4'h0;
        byteNo_r   <= 2'h0;
        sdaOe_r    <= 1'b0;
      end else if (busStop) begin
        serState_r <= thermal_pkg::SER_IDLE;
        sdaOe_r    <= 1'b0;
      end else begin
        unique case (serState_r)
          thermal_pkg::SER_IDLE: begin
            sdaOe_r <= 1'b0;
          end
          thermal_pkg::SER_RX: begin
            if (sclRise) begin
              shift_r  <= {shift_r[6:0], sdaS2};
              bitCnt_r <= bitCnt_r + 4'h1;
            end else if (sclFall && bitCnt_r == 4'h8) begin
              bitCnt_r <= 4'h0;
              if (byteNo_r == 2'h0) begin
                if (shift_r[7:1] == ownAddr) begin
                  readMode_r <= shift_r[0];
                  sdaOe_r    <= 1'b1;
                  serState_r <= thermal_pkg::SER_ACK;
                  byteNo_r   <= 2'h1;
                end else begin
                  serState_r <= thermal_pkg::SER_IDLE;
                end
              end else begin
                sdaOe_r    <= 1'b1;
                serState_r <= thermal_pkg::SER_ACK;
                byteNo_r   <= 2'h2;
                if (byteNo_r == 2'h1) begin
                  ptr_r <= shift_r;
                end else begin
                  serWr_r <= '{en: 1'b1, addr: ptr_r, data: shift_r};
                end
              end
            end
          end
          thermal_pkg::SER_ACK: begin
            if (sclFall) begin
              if (readMode_r) begin
                // first data bit goes out on the edge that ends the ack
                shift_r    <= {ptrData[6:0], 1'b0};
                sdaOe_r    <= !ptrData[7];
                serRd_r    <= 1'b1;
                bitCnt_r   <= 4'h1;
                serState_r <= thermal_pkg::SER_TX;
              end else begin
                sdaOe_r    <= 1'b0;
                bitCnt_r   <= 4'h0;
                serState_r <= thermal_pkg::SER_RX;
              end
            end
          end
          thermal_pkg::SER_TX: begin
            if (sclFall) begin
              if (bitCnt_r == 4'h8) begin
                sdaOe_r    <= 1'b0;
                serState_r <= thermal_pkg::SER_MACK;
              end else begin
                sdaOe_r  <= !shift_r[7];
                shift_r  <= {shift_r[6:0], 1'b0};
                bitCnt_r <= bitCnt_r + 4'h1;
              end
            end
          end
          thermal_pkg::SER_MACK: begin
            if (sclRise) begin
              // a host ack asks for the same register again
              serState_r <= sdaS2 ? thermal_pkg::SER_IDLE : thermal_pkg::SER_ACK;
            end
          end
        endcase
      end
    end
  end

  assign sdaOut = 1'b0;
  assign sdaOe  = sdaOe_r;

  // ---------------- register access ----------------
  // the plain port wins a same-cycle collision with a serial write
  assign wrSel   = regWr ? thermal_pkg::reg_wr_t'{en: 1'b1, addr: regAddr, data: regWdata}
                         : serWr_r;
  assign anyRead = regRd || serRd_r;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      config_r     <= thermal_pkg::RST_CONFIG;
      setLocal_r   <= thermal_pkg::RST_SET_LOCAL;
      hystLocal_r  <= thermal_pkg::RST_HYST_LOCAL;
      setRemote_r  <= thermal_pkg::RST_SET_REMOTE;
      hystRemote_r <= thermal_pkg::RST_HYST_REMOTE;
      critSet_r    <= thermal_pkg::RST_OVERTEMP_OUT_N_SET;
      critHyst_r   <= thermal_pkg::RST_OVERTEMP_OUT_N_HYST;
      irqMask_r    <= thermal_pkg::RST_IRQ_MASK;
    end else if (wrSel.en) begin
      unique case (wrSel.addr)
        thermal_pkg::REG_CONFIG:      config_r     <= wrSel.data & thermal_pkg::CFG_WR_MASK;
        thermal_pkg::REG_SET_LOCAL:   setLocal_r   <= wrSel.data;
        thermal_pkg::REG_HYST_LOCAL:  hystLocal_r  <= wrSel.data;
        thermal_pkg::REG_SET_REMOTE:  setRemote_r  <= wrSel.data;
        thermal_pkg::REG_HYST_REMOTE: hystRemote_r <= wrSel.data;
        thermal_pkg::REG_OVERTEMP_OUT_N_SET:    critSet_r    <= wrSel.data;
        thermal_pkg::REG_OVERTEMP_OUT_N_HYST:   critHyst_r   <= wrSel.data;
        thermal_pkg::REG_IRQ_MASK:    irqMask_r    <= wrSel.data[2:0];
        default:                      ;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      regRdata_r <= 8'h00;
    end else if (regRd) begin
      regRdata_r <= regRead(regAddr);
    end
  end

  assign regRdata = regRdata_r;

  // ---------------- conversion sequencer ----------------
  // shutdown aborts a conversion; the next run starts again at the remote zone
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      converting_r <= 1'b0;
      zoneRemote_r <= 1'b1;
      convCnt_r    <= 12'h000;
    end else if (config_r[thermal_pkg::CFG_SHUTDOWN]) begin
      converting_r <= 1'b0;
      zoneRemote_r <= 1'b1;
      convCnt_r    <= 12'h000;
    end else if (!converting_r) begin
      converting_r <= 1'b1;
      convCnt_r    <= zoneRemote_r ? thermal_pkg::CONV_REMOTE_CYC - 12'h001
                                   : thermal_pkg::CONV_LOCAL_CYC - 12'h001;
    end else if (convCnt_r == 12'h000) begin
      converting_r <= 1'b0;
      zoneRemote_r <= !zoneRemote_r;
    end else begin
      convCnt_r <= convCnt_r - 12'h001;
    end
  end

  assign measDone      = converting_r && convCnt_r == 12'h000;
  assign adcStart      = !converting_r && !config_r[thermal_pkg::CFG_SHUTDOWN];
  assign adcZoneRemote = zoneRemote_r;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      tempLocal_r  <= thermal_pkg::RST_TEMP;
      tempRemote_r <= thermal_pkg::RST_TEMP;
    end else if (measDone) begin
      if (zoneRemote_r) begin
        tempRemote_r <= adcData;
      end else begin
        tempLocal_r  <= adcData;
      end
    end
  end

  // ---------------- threshold comparators ----------------
  assign evtLocal  = measDone && !zoneRemote_r &&
                     (aboveLocal_r ? sgt(hystLocal_r, adcData)
                                   : sgt(adcData, setLocal_r));
  assign evtRemote = measDone && zoneRemote_r &&
                     (aboveRemote_r ? sgt(hystRemote_r, adcData)
                                    : sgt(adcData, setRemote_r));
  assign evtCrit   = measDone && zoneRemote_r &&
                     (critActive_r ? sgt(critHyst_r, adcData)
                                   : sgt(adcData, critSet_r));

  // each event flips the zone state, so it then waits for the other crossing
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      aboveLocal_r  <= 1'b0;
      aboveRemote_r <= 1'b0;
      critActive_r  <= 1'b0;
    end else begin
      if (evtLocal) begin
        aboveLocal_r <= !aboveLocal_r;
      end
      if (evtRemote) begin
        aboveRemote_r <= !aboveRemote_r;
      end
      if (evtCrit) begin
        critActive_r <= !critActive_r;
      end
    end
  end

  // ---------------- event output ----------------
  // a new event in the same cycle as a read keeps the latch set, so the output is asserted again one cycle later
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      intLatch_r <= 1'b0;
    end else if (evtLocal || evtRemote) begin
      intLatch_r <= 1'b1;
    end else if (anyRead) begin
      intLatch_r <= 1'b0;
    end
  end

  // comparator mode follows the zone state; interrupt mode the latch
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      eventOe_r <= 1'b0;
    end else if (config_r[thermal_pkg::CFG_EVENT_MASK]) begin
      eventOe_r <= 1'b0;
    end else if (config_r[thermal_pkg::CFG_MODE]) begin
      eventOe_r <= intLatch_r && !anyRead;
    end else begin
      eventOe_r <= aboveLocal_r || aboveRemote_r;
    end
  end

  assign eventOutN      = 1'b0;
  assign eventOutNOe    = eventOe_r;
  assign overtempOutN   = 1'b0;
  assign overtempOutNOe = critActive_r;

  // ---------------- status and interrupt ----------------
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      status_r <= thermal_pkg::RST_STATUS;
    end else begin
      // set wins over a write-one clear in the same cycle
      status_r <= (status_r & ~((wrSel.en && wrSel.addr == thermal_pkg::REG_STATUS)
                                ? wrSel.data[2:0] : 3'h0))
                | {evtCrit, evtRemote, evtLocal};
    end
  end

  assign irq = |(status_r & irqMask_r);

endmodule
`default_nettype wire
